/* design/wwc_defines.svh */
`ifndef WWC_DEFINES_SVH
`define WWC_DEFINES_SVH
// register offsets
`define WWC_OFF_WAKE_CFG 8'h00
`define WWC_OFF_SYS_CTRL 8'h04
`define WWC_OFF_CLK_STOP 8'h08
`define WWC_OFF_WAIT_CMD 8'h0C
`define WWC_OFF_STATUS 8'h10
// wake_clock_config_reg fields
`define WWC_WSEL_LSB 0
`define WWC_PRESC_LSB 2
`define WWC_STAB_LSB 8
// system_clock_ctrl_reg fields
`define WWC_DIV_LSB 0
`define WWC_FSTOP_BIT 4
`define WWC_FSTOP_WAIT_BIT 5
`define WWC_LPE_BIT 6
`define WWC_CLKOUT_BIT 7
// clock_stop_ctrl_reg fields
`define WWC_SRC_LSB 0
`define WWC_XIN_RUN_BIT 2
`define WWC_HOCO_RUN_BIT 3
`define WWC_LOCO_STOP_BIT 4
`define WWC_XIN_PINS_BIT 5
// wait command and status fields
`define WWC_WAIT_GO_BIT 0
`define WWC_ST_CPU_BIT 8
`define WWC_ST_FLASH_BIT 9
`define WWC_ST_LP_BIT 10
// writable masks and reset values
`define WWC_WAKE_CFG_MASK 32'h00000F1F
`define WWC_SYS_CTRL_MASK 32'h000000F7
`define WWC_CLK_STOP_MASK 32'h0000003F
`define WWC_WAKE_CFG_RST 32'h00000002
`define WWC_SYS_CTRL_RST 32'h00000000
`define WWC_CLK_STOP_RST 32'h00000002
// timing
`define WWC_CLK_MHZ 250
`define WWC_PWR_STAB_US 100
`define WWC_FLASH_ACT_US 60
`define WWC_RESTART_CPU_CYC 2
`define WWC_ISEQ_CPU_CYC 20
`define WWC_STAB_UNIT_CYC 256
`endif

/* design/wwc_pkg.sv */
package wwc_pkg;
   typedef enum logic [1:0] {
      WWC_SRC_XIN = 2'h0,
      WWC_SRC_HOCO = 2'h1,
      WWC_SRC_LOCO = 2'h2
   } wwc_src_type;
   typedef enum logic [6:0] {
      WWC_ST_RUN = 7'h01,
      WWC_ST_WAIT = 7'h02,
      WWC_ST_PWR = 7'h04,
      WWC_ST_FLASH = 7'h08,
      WWC_ST_STAB = 7'h10,
      WWC_ST_RESTART = 7'h20,
      WWC_ST_ISEQ = 7'h40
   } wwc_state_type;
endpackage : wwc_pkg

/* design/wwc_phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wwc_phase_timer #(
   parameter int TW = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [TW-1:0] load_val_i,
   input wire logic tick_i,
   output logic done_o
);
   logic [TW-1:0] cnt_reg;
   logic [TW-1:0] cnt_next;
   logic arm_reg;
   logic arm_next;
   logic done_reg;
   logic done_next;

   // counts load_val_i ticks, then one done pulse
   always_comb
   begin
      cnt_next = cnt_reg;
      arm_next = arm_reg;
      done_next = 1'b0;
      if (load_i)
      begin
         cnt_next = load_val_i;
         arm_next = 1'b1;
      end
      else if (arm_reg && tick_i)
      begin
         if (cnt_reg <= TW'(1))
         begin
            arm_next = 1'b0;
            done_next = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg - TW'(1);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         arm_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         arm_reg <= arm_next;
         done_reg <= done_next;
      end
   end

   assign done_o = done_reg;
endmodule : wwc_phase_timer
`default_nettype wire

/* design/wwc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wwc_defines.svh"
module wwc_top #(
   parameter int PWR_STAB_CYC = `WWC_PWR_STAB_US * `WWC_CLK_MHZ,
   parameter int FLASH_ACT_CYC = `WWC_FLASH_ACT_US * `WWC_CLK_MHZ,
   parameter int STAB_UNIT_CYC = `WWC_STAB_UNIT_CYC,
   parameter int TW = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic wake_irq_i,
   output logic cpu_clk_en_o,
   output logic irq_exec_o,
   output wwc_pkg::wwc_src_type sys_clk_sel_o,
   output logic [2:0] clk_div_o,
   output logic xin_osc_en_o,
   output logic hoco_en_o,
   output logic loco_en_o,
   output logic xin_pins_osc_o,
   output logic clkout_en_o,
   output logic flash_en_o,
   output logic low_power_o
);
   import wwc_pkg::*;

   localparam logic [TW-1:0] PWR_LD = TW'(PWR_STAB_CYC);
   localparam logic [TW-1:0] FLASH_LD = TW'(FLASH_ACT_CYC);
   localparam logic [TW-1:0] RESTART_LD = TW'(`WWC_RESTART_CPU_CYC);
   localparam logic [TW-1:0] ISEQ_LD = TW'(`WWC_ISEQ_CPU_CYC);

   // byte-lane merge of a write into a register
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel,
                                          input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction : wmerge

   // one pulse every 2^div system clocks
   function automatic logic cpu_tick(input logic [6:0] cnt,
                                     input logic [2:0] div);
      logic [6:0] m;
      m = 7'((8'h01 << div) - 8'h01);
      return (cnt & m) == m;
   endfunction : cpu_tick

   function automatic logic [TW-1:0] stab_cycles(input logic [3:0] f);
      return TW'((32'(f) + 32'h1) * 32'(STAB_UNIT_CYC));
   endfunction : stab_cycles

   wwc_state_type state_reg;
   wwc_state_type state_next;
   logic first_reg;
   logic first_next;
   logic [31:0] wake_cfg_reg;
   logic [31:0] wake_cfg_next;
   logic [31:0] sys_ctrl_reg;
   logic [31:0] sys_ctrl_next;
   logic [31:0] clk_stop_reg;
   logic [31:0] clk_stop_next;
   logic [1:0] prev_src_reg;
   logic [1:0] prev_src_next;
   logic [6:0] div_cnt_reg;
   logic [6:0] div_cnt_next;
   logic cpu_en_reg;
   logic cpu_en_next;
   logic irq_exec_reg;
   logic irq_exec_next;
   logic flash_en_reg;
   logic flash_en_next;
   logic lp_reg;
   logic lp_next;
   logic pins_osc_reg;
   logic pins_osc_next;
   logic clkout_reg;
   logic clkout_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic wr;
   logic advance;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic tmr_tick;
   logic tmr_done;
   logic [1:0] wake_sel;
   logic [1:0] cur_src;

   assign wake_sel = wake_cfg_reg[`WWC_WSEL_LSB +: 2];
   assign cur_src = clk_stop_reg[`WWC_SRC_LSB +: 2];
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

   wwc_phase_timer #(
      .TW(TW)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(tmr_load),
      .load_val_i(tmr_val),
      .tick_i(tmr_tick),
      .done_o(tmr_done)
   );

   // register file and wake-up sequencer
   always_comb
   begin
      state_next = state_reg;
      wake_cfg_next = wake_cfg_reg;
      sys_ctrl_next = sys_ctrl_reg;
      clk_stop_next = clk_stop_reg;
      prev_src_next = prev_src_reg;
      div_cnt_next = div_cnt_reg + 7'h01;
      cpu_en_next = cpu_en_reg;
      flash_en_next = flash_en_reg;
      lp_next = lp_reg;
      irq_exec_next = 1'b0;
      advance = 1'b0;
      tmr_load = 1'b0;
      tmr_val = '0;
      tmr_tick = 1'b1;
      if (wr)
      begin
         if (wb_adr_i == `WWC_OFF_WAKE_CFG)
         begin
            wake_cfg_next = wmerge(wake_cfg_reg, wb_dat_i, wb_sel_i,
                                   `WWC_WAKE_CFG_MASK);
         end
         else if (wb_adr_i == `WWC_OFF_SYS_CTRL)
         begin
            sys_ctrl_next = wmerge(sys_ctrl_reg, wb_dat_i, wb_sel_i,
                                   `WWC_SYS_CTRL_MASK);
         end
         else if (wb_adr_i == `WWC_OFF_CLK_STOP)
         begin
            clk_stop_next = wmerge(clk_stop_reg, wb_dat_i, wb_sel_i,
                                   `WWC_CLK_STOP_MASK);
         end
      end
      case (state_reg)
         WWC_ST_RUN:
         begin
            if (wr && wb_adr_i == `WWC_OFF_WAIT_CMD && wb_sel_i[0]
                && wb_dat_i[`WWC_WAIT_GO_BIT])
            begin
               state_next = WWC_ST_WAIT;
               prev_src_next = cur_src;
               cpu_en_next = 1'b0;
               lp_next = sys_ctrl_reg[`WWC_LPE_BIT];
               if (sys_ctrl_reg[`WWC_FSTOP_WAIT_BIT])
               begin
                  flash_en_next = 1'b0;
               end
            end
         end
         WWC_ST_WAIT:
         begin
            if (wake_irq_i)
            begin
               state_next = WWC_ST_PWR;
               clk_stop_next[`WWC_SRC_LSB +: 2] = wake_sel;
               sys_ctrl_next[`WWC_DIV_LSB +: 3] =
                  wake_cfg_reg[`WWC_PRESC_LSB +: 3];
               if (wake_sel == WWC_SRC_HOCO)
               begin
                  clk_stop_next[`WWC_HOCO_RUN_BIT] = 1'b1;
               end
               if (wake_sel == WWC_SRC_LOCO)
               begin
                  clk_stop_next[`WWC_LOCO_STOP_BIT] = 1'b0;
               end
            end
         end
         WWC_ST_PWR:
         begin
            if (first_reg)
            begin
               tmr_load = sys_ctrl_reg[`WWC_LPE_BIT];
               tmr_val = PWR_LD;
               advance = !sys_ctrl_reg[`WWC_LPE_BIT];
            end
            else
            begin
               advance = tmr_done;
            end
            if (advance)
            begin
               state_next = WWC_ST_FLASH;
               lp_next = 1'b0;
            end
         end
         WWC_ST_FLASH:
         begin
            if (first_reg)
            begin
               tmr_load = !sys_ctrl_reg[`WWC_FSTOP_BIT]
                          && sys_ctrl_reg[`WWC_FSTOP_WAIT_BIT];
               tmr_val = FLASH_LD;
               advance = !tmr_load;
            end
            else
            begin
               advance = tmr_done;
            end
            if (advance)
            begin
               state_next = WWC_ST_STAB;
               flash_en_next = !sys_ctrl_reg[`WWC_FSTOP_BIT];
            end
         end
         WWC_ST_STAB:
         begin
            if (first_reg)
            begin
               tmr_load = cur_src != prev_src_reg;
               tmr_val = stab_cycles(wake_cfg_reg[`WWC_STAB_LSB +: 4]);
               advance = !tmr_load;
            end
            else
            begin
               advance = tmr_done;
            end
            if (advance)
            begin
               state_next = WWC_ST_RESTART;
            end
         end
         WWC_ST_RESTART:
         begin
            tmr_tick = cpu_tick(div_cnt_reg, sys_ctrl_reg[`WWC_DIV_LSB +: 3]);
            tmr_load = first_reg;
            tmr_val = RESTART_LD;
            if (!first_reg && tmr_done)
            begin
               state_next = WWC_ST_ISEQ;
               cpu_en_next = 1'b1;
            end
         end
         WWC_ST_ISEQ:
         begin
            tmr_tick = cpu_tick(div_cnt_reg, sys_ctrl_reg[`WWC_DIV_LSB +: 3]);
            tmr_load = first_reg;
            tmr_val = ISEQ_LD;
            if (!first_reg && tmr_done)
            begin
               state_next = WWC_ST_RUN;
               irq_exec_next = 1'b1;
            end
         end
         default:
         begin
            state_next = WWC_ST_RUN;
         end
      endcase
      first_next = state_next != state_reg;
      pins_osc_next = clk_stop_next[`WWC_XIN_PINS_BIT]
                      || clk_stop_next[`WWC_SRC_LSB +: 2] == WWC_SRC_XIN;
      clkout_next = sys_ctrl_next[`WWC_CLKOUT_BIT]
                    && clk_stop_next[`WWC_SRC_LSB +: 2] != WWC_SRC_XIN;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= WWC_ST_RUN;
         first_reg <= 1'b0;
         wake_cfg_reg <= `WWC_WAKE_CFG_RST;
         sys_ctrl_reg <= `WWC_SYS_CTRL_RST;
         clk_stop_reg <= `WWC_CLK_STOP_RST;
         prev_src_reg <= WWC_SRC_LOCO;
         div_cnt_reg <= 7'h00;
         cpu_en_reg <= 1'b1;
         irq_exec_reg <= 1'b0;
         flash_en_reg <= 1'b1;
         lp_reg <= 1'b0;
         pins_osc_reg <= 1'b0;
         clkout_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         first_reg <= first_next;
         wake_cfg_reg <= wake_cfg_next;
         sys_ctrl_reg <= sys_ctrl_next;
         clk_stop_reg <= clk_stop_next;
         prev_src_reg <= prev_src_next;
         div_cnt_reg <= div_cnt_next;
         cpu_en_reg <= cpu_en_next;
         irq_exec_reg <= irq_exec_next;
         flash_en_reg <= flash_en_next;
         lp_reg <= lp_next;
         pins_osc_reg <= pins_osc_next;
         clkout_reg <= clkout_next;
      end
   end

   // wishbone answer and read data
   always_comb
   begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      rdat_next = 32'h00000000;
      if (ack_next && !wb_we_i)
      begin
         if (wb_adr_i == `WWC_OFF_WAKE_CFG)
         begin
            rdat_next = wake_cfg_reg;
         end
         else if (wb_adr_i == `WWC_OFF_SYS_CTRL)
         begin
            rdat_next = sys_ctrl_reg;
         end
         else if (wb_adr_i == `WWC_OFF_CLK_STOP)
         begin
            rdat_next = clk_stop_reg;
         end
         else if (wb_adr_i == `WWC_OFF_STATUS)
         begin
            rdat_next[6:0] = state_reg;
            rdat_next[`WWC_ST_CPU_BIT] = cpu_en_reg;
            rdat_next[`WWC_ST_FLASH_BIT] = flash_en_reg;
            rdat_next[`WWC_ST_LP_BIT] = lp_reg;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign cpu_clk_en_o = cpu_en_reg;
   assign irq_exec_o = irq_exec_reg;
   assign sys_clk_sel_o = wwc_src_type'(clk_stop_reg[`WWC_SRC_LSB +: 2]);
   assign clk_div_o = sys_ctrl_reg[`WWC_DIV_LSB +: 3];
   assign xin_osc_en_o = clk_stop_reg[`WWC_XIN_RUN_BIT];
   assign hoco_en_o = clk_stop_reg[`WWC_HOCO_RUN_BIT];
   assign loco_en_o = !clk_stop_reg[`WWC_LOCO_STOP_BIT];
   assign xin_pins_osc_o = pins_osc_reg;
   assign clkout_en_o = clkout_reg;
   assign flash_en_o = flash_en_reg;
   assign low_power_o = lp_reg;
endmodule : wwc_top
`default_nettype wire

/* sim/wwc_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wwc_top_checker
   import wwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cpu_clk_en_o,
   input wire logic irq_exec_o,
   input wire wwc_pkg::wwc_src_type sys_clk_sel_o,
   input wire logic xin_osc_en_o,
   input wire logic hoco_en_o,
   input wire logic loco_en_o,
   input wire logic flash_en_o,
   input wire logic low_power_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_exec_pulse: assert property (irq_exec_o |=> !irq_exec_o)
      else $error("exec pulse longer than one cycle");
   a_exec_clock_on: assert property (irq_exec_o |-> cpu_clk_en_o)
      else $error("exec without cpu clock");
   a_iseq_gap: assert property ($rose(cpu_clk_en_o) |-> !irq_exec_o [*8])
      else $error("interrupt sequence too short");
   a_iseq_length: assert property (irq_exec_o |-> $past(cpu_clk_en_o, 19))
      else $error("cpu clock not on for twenty cycles");
   a_reset_osc: assert property ($past(rst_i) |-> loco_en_o && !xin_osc_en_o && !hoco_en_o)
      else $error("oscillator state wrong after reset");
   a_hoco_start: assert property (($changed(sys_clk_sel_o) && !cpu_clk_en_o &&
      sys_clk_sel_o == WWC_SRC_HOCO) |-> hoco_en_o)
      else $error("high-speed oscillator not started on wake");
   a_wait_min: assert property ($fell(cpu_clk_en_o) |-> !cpu_clk_en_o [*4])
      else $error("cpu clock back too early");
   a_flash_order: assert property (($rose(flash_en_o) && !cpu_clk_en_o) |->
      !cpu_clk_en_o [*2])
      else $error("flash activation not before clock restart");
   a_low_power_wait: assert property ($rose(low_power_o) |-> !cpu_clk_en_o)
      else $error("low power while cpu clock runs");
   c_exec: cover property (irq_exec_o);
   c_low_power: cover property ($rose(low_power_o));
   c_hoco_wake: cover property ($rose(hoco_en_o) && !cpu_clk_en_o);
endmodule : wwc_top_checker
bind wwc_top wwc_top_checker u_chk (.clk_i, .rst_i, .cpu_clk_en_o, .irq_exec_o,
   .sys_clk_sel_o, .xin_osc_en_o, .hoco_en_o, .loco_en_o, .flash_en_o, .low_power_o);
`default_nettype wire

/* sim/test_wwc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_wwc_top;
   import wwc_pkg::*;
   localparam int PWR = 20;
   localparam int FLS = 16;
   localparam int SU = 4;
   typedef struct packed {
      logic [1:0] ent;
      logic [1:0] wsel;
      logic [2:0] presc;
      logic [3:0] stab;
      logic low_power_wait_enable;
      logic fsw;
      logic fst;
      logic xp;
      logic co;
   } wwc_row_type;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wake_irq_i = 1'b0;
   logic cpu_clk_en_o;
   logic irq_exec_o;
   wwc_src_type sys_clk_sel_o;
   logic [2:0] clk_div_o;
   logic xin_osc_en_o;
   logic hoco_en_o;
   logic loco_en_o;
   logic xin_pins_osc_o;
   logic clkout_en_o;
   logic flash_en_o;
   logic low_power_o;
   logic [31:0] rdat;
   int failures = 0;
   int checks_done = 0;
   int lat;
   int lo;
   wwc_row_type r;
   // entry src, wake src, prescale, stab, lpe, stop in wait, stop, pins, clock out
   wwc_row_type rows [4] = '{
      '{2'h2, 2'h2, 3'h0, 4'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
      '{2'h2, 2'h1, 3'h1, 4'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h1, 2'h0, 3'h2, 4'hF, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1},
      '{2'h0, 2'h0, 3'h0, 4'hF, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0}
   };
   wwc_top #(.PWR_STAB_CYC(PWR), .FLASH_ACT_CYC(FLS), .STAB_UNIT_CYC(SU)) dut (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .wake_irq_i, .cpu_clk_en_o, .irq_exec_o, .sys_clk_sel_o,
      .clk_div_o, .xin_osc_en_o, .hoco_en_o, .loco_en_o, .xin_pins_osc_o, .clkout_en_o,
      .flash_en_o, .low_power_o);
   always #2 clk_i = ~clk_i;
   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, released after ack is seen or after 50 clocks without ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50)
      begin
         failures++;
         stop_test();
      end
   endtask : wb
   task automatic chk_rst();
      @(posedge clk_i);
      chk(cpu_clk_en_o, 1'b1);
      chk(loco_en_o, 1'b1);
      chk(xin_osc_en_o, 1'b0);
      chk(hoco_en_o, 1'b0);
      chk(sys_clk_sel_o, WWC_SRC_LOCO);
   endtask : chk_rst
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_rst();
      wb(1'b0, 8'h00, 32'h0, rdat);
      chk(rdat, 32'h00000002);
      wb(1'b0, 8'h08, 32'h0, rdat);
      chk(rdat, 32'h00000002);
      wb(1'b0, 8'h20, 32'h0, rdat);
      chk(rdat, 32'h00000000);
      // wake request outside wait
      wake_irq_i <= 1'b1;
      repeat (6)
      begin
         @(posedge clk_i);
         chk(irq_exec_o, 1'b0);
      end
      wake_irq_i <= 1'b0;
      foreach (rows[i])
      begin
         r = rows[i];
         wb(1'b1, 8'h00, {20'h0, r.stab, 3'h0, r.presc, r.wsel}, rdat);
         wb(1'b1, 8'h04, {24'h0, r.co, r.low_power_wait_enable, r.fsw, r.fst, 4'h0}, rdat);
         wb(1'b1, 8'h08, {26'h0, r.xp, 1'b0, r.ent == 2'h1, 1'b1, r.ent}, rdat);
         chk(xin_osc_en_o, 1'b1);
         chk(clkout_en_o, r.co && r.ent != 2'h0);
         chk(xin_pins_osc_o, r.xp || r.ent == 2'h0);
         wb(1'b1, 8'h0C, 32'h00000001, rdat);
         repeat (2) @(posedge clk_i);
         chk(cpu_clk_en_o, 1'b0);
         chk(low_power_o, r.low_power_wait_enable);
         chk(flash_en_o, !r.fsw);
         wb(1'b0, 8'h10, 32'h0, rdat);
         chk(rdat, {21'h0, r.low_power_wait_enable, !r.fsw, 2'h0, 7'h02});
         wake_irq_i <= 1'b1;
         lat = 0;
         do
         begin
            @(posedge clk_i);
            lat++;
         end
         while (irq_exec_o !== 1'b1 && lat < 3000);
         wake_irq_i <= 1'b0;
         lo = 22 << r.presc;
         if (r.low_power_wait_enable)
            lo += PWR;
         if (r.fsw && !r.fst)
            lo += FLS;
         if (r.wsel != r.ent)
            lo += (r.stab + 1) * SU;
         chk(lat >= lo && lat <= lo + 20, 1'b1);
         if (lat >= 3000)
            stop_test();
         chk(sys_clk_sel_o, r.wsel);
         chk(clk_div_o, r.presc);
         chk(cpu_clk_en_o, 1'b1);
         chk(flash_en_o, !r.fst);
         chk(xin_pins_osc_o, r.xp || r.wsel == 2'h0);
         chk(clkout_en_o, r.co && r.wsel != 2'h0);
         if (r.wsel == 2'h1)
            chk(hoco_en_o, 1'b1);
      end
      // reset in the middle of a wait
      wb(1'b1, 8'h0C, 32'h00000001, rdat);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_rst();
      wb(1'b0, 8'h10, 32'h0, rdat);
      chk(rdat, 32'h00000301);
      stop_test();
   end
endmodule : test_wwc_top
`default_nettype wire
